// ===== rtl/cpcc_pkg.sv
// Package: register map, keys, reset values and field layouts of the clock and power control block
package cpcc_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // Register byte addresses
  localparam logic [31:0] POWER_KEY_PRE_ADDR  = 32'hffff0404;
  localparam logic [31:0] POWER_MODE_ADDR     = 32'hffff0408;
  localparam logic [31:0] POWER_KEY_POST_ADDR = 32'hffff040c;
  localparam logic [31:0] PLL_KEY_PRE_ADDR    = 32'hffff0410;
  localparam logic [31:0] PLL_SOURCE_ADDR     = 32'hffff0414;
  localparam logic [31:0] PLL_KEY_POST_ADDR   = 32'hffff0418;
  localparam logic [31:0] LP_TRIM_ADDR        = 32'hffff042c;
  localparam logic [31:0] CAL_CONTROL_ADDR    = 32'hffff0440;
  localparam logic [31:0] CAL_STATE_ADDR      = 32'hffff0444;
  localparam logic [31:0] REF_CAL_COUNT_ADDR  = 32'hffff0448;
  localparam logic [31:0] LP_CAL_COUNT_ADDR   = 32'hffff044c;

  // Key values
  localparam logic [31:0] POWER_KEY_PRE_VAL  = 32'h00000001;
  localparam logic [31:0] POWER_KEY_POST_VAL = 32'h000000f4;
  localparam logic [31:0] PLL_KEY_PRE_VAL    = 32'h000000aa;
  localparam logic [31:0] PLL_KEY_POST_VAL   = 32'h00000055;

  // Power mode control layout, bit 7 down to bit 0
  typedef struct packed {
    logic       prec_in_en;
    logic       xtal_en;
    logic       pll_en;
    logic       periph_en;
    logic       core_en;
    logic [2:0] core_divide_field;
  } cpcc_power_t;

  // Calibration control layout, bit 7 down to bit 0
  typedef struct packed {
    logic [2:0] rsvd;
    logic       src_xtal;
    logic       cal_reset;
    logic       clr_lp;
    logic       clr_ref;
    logic       enable;
  } cpcc_cal_ctrl_t;

  localparam logic [7:0] POWER_MODE_RST = 8'h79;
  localparam logic [1:0] PLL_SOURCE_RST = 2'h0;
  localparam logic [3:0] LP_TRIM_RST    = 4'h8;

  // PLL reference source codes
  localparam logic [1:0] SRC_LOWPOWER  = 2'h0;
  localparam logic [1:0] SRC_PRECISION = 2'h1;
  localparam logic [1:0] SRC_CRYSTAL   = 2'h2;

  // One-hot reference enables: bit 0 low power, bit 1 precision, bit 2 crystal
  localparam logic [2:0] REF_SEL_LOWPOWER  = 3'h1;
  localparam logic [2:0] REF_SEL_PRECISION = 3'h2;
  localparam logic [2:0] REF_SEL_CRYSTAL   = 3'h4;

  localparam int unsigned REF_CNT_W = 9;
  localparam int unsigned LP_CNT_W  = 10;
  localparam logic [8:0] REF_CNT_END = 9'h1ff;
  localparam logic [1:0] LP_DIV_LAST = 2'h3;

  // Calibration state bit positions
  localparam int unsigned CAL_BUSY_BIT = 0;
  localparam int unsigned CAL_DONE_BIT = 1;

  typedef enum logic [2:0] {
    CPCC_KEY_IDLE  = 3'b001,
    CPCC_KEY_ARMED = 3'b010,
    CPCC_KEY_PEND  = 3'b100
  } cpcc_key_state_t;

endpackage

// ===== rtl/cpcc_top.sv
// Clock and power control with key-protected registers and low-power oscillator calibration

// Key sequencer guarding one protected register
module cpcc_key_guard #(
  parameter logic [31:0] PRE_ADDR  = 32'h0,
  parameter logic [31:0] PROT_ADDR = 32'h4,
  parameter logic [31:0] POST_ADDR = 32'h8,
  parameter logic [31:0] PRE_KEY   = 32'h0,
  parameter logic [31:0] POST_KEY  = 32'h0
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  output logic             commit_out,
  output logic [7:0]       commit_data_out
);

  cpcc_pkg::cpcc_key_state_t state_ff;
  logic                      commit_ff;
  logic [7:0]                data_ff;
  logic                      pre_hit;
  logic                      post_hit;

  assign pre_hit  = (addr_in == PRE_ADDR) && (wdata_in == PRE_KEY);
  assign post_hit = (addr_in == POST_ADDR) && (wdata_in == POST_KEY);

  // Any other write breaks the sequence; reads leave it alone
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff <= cpcc_pkg::CPCC_KEY_IDLE;
    end else if (wr_in) begin
      case (state_ff)
        cpcc_pkg::CPCC_KEY_IDLE: begin
          state_ff <= pre_hit ? cpcc_pkg::CPCC_KEY_ARMED : cpcc_pkg::CPCC_KEY_IDLE;
        end
        cpcc_pkg::CPCC_KEY_ARMED: begin
          if (addr_in == PROT_ADDR) begin
            state_ff <= cpcc_pkg::CPCC_KEY_PEND;
          end else if (pre_hit) begin
            state_ff <= cpcc_pkg::CPCC_KEY_ARMED;
          end else begin
            state_ff <= cpcc_pkg::CPCC_KEY_IDLE;
          end
        end
        cpcc_pkg::CPCC_KEY_PEND: begin
          state_ff <= pre_hit ? cpcc_pkg::CPCC_KEY_ARMED : cpcc_pkg::CPCC_KEY_IDLE;
        end
        default: begin
          state_ff <= cpcc_pkg::CPCC_KEY_IDLE;
        end
      endcase
    end
  end

  // Value is held aside until the postwrite key confirms it
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_ff <= 8'h00;
    end else if (wr_in && (state_ff == cpcc_pkg::CPCC_KEY_ARMED) && (addr_in == PROT_ADDR)) begin
      data_ff <= wdata_in[7:0];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      commit_ff <= 1'b0;
    end else begin
      commit_ff <= wr_in && (state_ff == cpcc_pkg::CPCC_KEY_PEND) && post_hit;
    end
  end

  assign commit_out      = commit_ff;
  assign commit_data_out = data_ff;

endmodule

// Overview of operation
// - Two-bit source picks low-power, precision or crystal reference; 11 reserved.
// - PLL source resets to zero; upper six bits reserved, written as zero.
// - Power control write needs prewrite key 0x01 before and 0xF4 after.
// - Power control resets to 0x79: core, peripherals, PLL, crystal on, divide by two.
// - Core divider field divides the 20.48 MHz PLL output by two to the field.
// - Bit 7 enables the precision 131 kHz input; oscillator enabled elsewhere too.
// - Bit 6 enables the external crystal circuitry.
// - Clearing bit 5 stops the PLL and its timers; wake-up sets it again.
// - PLL stops only when core, peripheral and PLL bits clear in one write.
// - Clearing bit 4 stops memories, GPIO, SPI and UART; wake-up sets it.
// - Peripherals stop only when core and peripheral bits clear together.
// - Clearing bit 3 stops the core; wake-up sets it; software adds dummy cycle.
// - Nine-bit reference counter and ten-bit low-power counter, optional divide by four.
// - Both counters stop when the reference counter reaches 0x1FF.
// - Trim register holds four user bits; larger value lowers the frequency.
// - A run lasts about 4 ms on precision, 16 ms on crystal reference.
// - PLL source write needs prewrite key 0xAA before and 0x55 after.
// - Calibration control selects crystal or precision reference and starts or aborts.
// - Status shows busy while counting and done until the low-power count is read.
module cpcc_top (
  input  wire logic               ref_clk_in,
  input  wire logic               rstn_in,
  input  wire logic [31:0]        addr_in,
  input  wire logic [31:0]        wdata_in,
  input  wire logic               wr_in,
  input  wire logic               rd_in,
  output logic      [31:0]        rdata_out,
  input  wire logic               wake_event_in,
  input  wire logic               lp_osc_in,
  input  wire logic               prec_osc_in,
  input  wire logic               xtal_osc_in,
  output cpcc_pkg::cpcc_power_t   power_ctrl_out,
  output logic      [2:0]         pll_ref_sel_out,
  output logic      [3:0]         lp_trim_out,
  output logic                    cal_busy_out
);

  cpcc_pkg::cpcc_power_t    pmc_ff;
  cpcc_pkg::cpcc_power_t    nxt_pmc;
  cpcc_pkg::cpcc_power_t    pmc_wr;
  cpcc_pkg::cpcc_cal_ctrl_t cal_wr;
  logic [1:0]               pll_src_ff;
  logic [2:0]               pll_ref_sel_ff;
  logic [3:0]               trim_ff;
  logic                     cal_src_xtal_ff;
  logic                     cal_reset_ff;
  logic                     cal_en_ff;
  logic                     cal_stop_ff;
  logic                     cal_done_ff;
  logic                     cal_busy_ff;
  logic [8:0]               ref_cnt_ff;
  logic [9:0]               lp_cnt_ff;
  logic [1:0]               lp_div_ff;
  logic [31:0]              rdata_ff;
  logic [31:0]              nxt_rdata;
  logic                     pow_commit;
  logic [7:0]               pow_data;
  logic                     pll_commit;
  logic [7:0]               pll_data;
  logic [2:0]               wake_sync_ff;
  logic [2:0]               lp_sync_ff;
  logic [2:0]               prec_sync_ff;
  logic [2:0]               xtal_sync_ff;
  logic                     wake_rise;
  logic                     lp_rise;
  logic                     prec_rise;
  logic                     xtal_rise;
  logic                     cal_wr_hit;
  logic                     cal_start;
  logic                     cal_running;
  logic                     ref_tick;
  logic                     lp_tick;
  logic                     ref_last;
  logic                     lp_count_read;

  cpcc_key_guard #(
    .PRE_ADDR  (cpcc_pkg::POWER_KEY_PRE_ADDR),
    .PROT_ADDR (cpcc_pkg::POWER_MODE_ADDR),
    .POST_ADDR (cpcc_pkg::POWER_KEY_POST_ADDR),
    .PRE_KEY   (cpcc_pkg::POWER_KEY_PRE_VAL),
    .POST_KEY  (cpcc_pkg::POWER_KEY_POST_VAL)
  ) u_power_guard (
    .ref_clk_in      (ref_clk_in),
    .rstn_in         (rstn_in),
    .wr_in           (wr_in),
    .addr_in         (addr_in),
    .wdata_in        (wdata_in),
    .commit_out      (pow_commit),
    .commit_data_out (pow_data)
  );

  cpcc_key_guard #(
    .PRE_ADDR  (cpcc_pkg::PLL_KEY_PRE_ADDR),
    .PROT_ADDR (cpcc_pkg::PLL_SOURCE_ADDR),
    .POST_ADDR (cpcc_pkg::PLL_KEY_POST_ADDR),
    .PRE_KEY   (cpcc_pkg::PLL_KEY_PRE_VAL),
    .POST_KEY  (cpcc_pkg::PLL_KEY_POST_VAL)
  ) u_pll_guard (
    .ref_clk_in      (ref_clk_in),
    .rstn_in         (rstn_in),
    .wr_in           (wr_in),
    .addr_in         (addr_in),
    .wdata_in        (wdata_in),
    .commit_out      (pll_commit),
    .commit_data_out (pll_data)
  );

  // Oscillators and wake-up arrive asynchronously; stage 0 feeds only stage 1
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_sync_ff <= 3'h0;
      lp_sync_ff   <= 3'h0;
      prec_sync_ff <= 3'h0;
      xtal_sync_ff <= 3'h0;
    end else begin
      wake_sync_ff <= {wake_sync_ff[1:0], wake_event_in};
      lp_sync_ff   <= {lp_sync_ff[1:0], lp_osc_in};
      prec_sync_ff <= {prec_sync_ff[1:0], prec_osc_in};
      xtal_sync_ff <= {xtal_sync_ff[1:0], xtal_osc_in};
    end
  end

  assign wake_rise = wake_sync_ff[1] & ~wake_sync_ff[2];
  assign lp_rise   = lp_sync_ff[1] & ~lp_sync_ff[2];
  assign prec_rise = prec_sync_ff[1] & ~prec_sync_ff[2];
  assign xtal_rise = xtal_sync_ff[1] & ~xtal_sync_ff[2];

  // Power mode control
  assign pmc_wr = cpcc_pkg::cpcc_power_t'(pow_data);

  always_comb begin
    nxt_pmc = pmc_ff;
    if (pow_commit) begin
      nxt_pmc.prec_in_en        = pmc_wr.prec_in_en;
      nxt_pmc.xtal_en           = pmc_wr.xtal_en;
      nxt_pmc.core_divide_field = pmc_wr.core_divide_field;
      nxt_pmc.core_en           = pmc_wr.core_en;
      // An enabled core keeps the peripherals up; either keeps the PLL up
      nxt_pmc.periph_en         = pmc_wr.periph_en | pmc_wr.core_en;
      nxt_pmc.pll_en            = pmc_wr.pll_en | pmc_wr.periph_en | pmc_wr.core_en;
    end
    // Wake-up wins over a simultaneous power-down commit
    if (wake_rise) begin
      nxt_pmc.core_en   = 1'b1;
      nxt_pmc.periph_en = 1'b1;
      nxt_pmc.pll_en    = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pmc_ff <= cpcc_pkg::cpcc_power_t'(cpcc_pkg::POWER_MODE_RST);
    end else begin
      pmc_ff <= nxt_pmc;
    end
  end

  // PLL reference source; only the low two bits are kept
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pll_src_ff <= cpcc_pkg::PLL_SOURCE_RST;
    end else if (pll_commit) begin
      pll_src_ff <= pll_data[1:0];
    end
  end

  // Reserved code keeps the always-running low-power oscillator as reference
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pll_ref_sel_ff <= cpcc_pkg::REF_SEL_LOWPOWER;
    end else begin
      case (pll_src_ff)
        cpcc_pkg::SRC_PRECISION: pll_ref_sel_ff <= cpcc_pkg::REF_SEL_PRECISION;
        cpcc_pkg::SRC_CRYSTAL:   pll_ref_sel_ff <= cpcc_pkg::REF_SEL_CRYSTAL;
        default:                 pll_ref_sel_ff <= cpcc_pkg::REF_SEL_LOWPOWER;
      endcase
    end
  end

  // Trim register; upper nibble not stored
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      trim_ff <= cpcc_pkg::LP_TRIM_RST;
    end else if (wr_in && (addr_in == cpcc_pkg::LP_TRIM_ADDR)) begin
      trim_ff <= wdata_in[3:0];
    end
  end

  // Calibration control
  assign cal_wr      = cpcc_pkg::cpcc_cal_ctrl_t'(wdata_in[7:0]);
  assign cal_wr_hit  = wr_in && (addr_in == cpcc_pkg::CAL_CONTROL_ADDR);
  assign cal_start   = cal_wr_hit && cal_wr.enable && !cal_en_ff;
  assign cal_running = cal_en_ff && !cal_reset_ff && !cal_stop_ff;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cal_src_xtal_ff <= 1'b0;
      cal_reset_ff    <= 1'b0;
      cal_en_ff       <= 1'b0;
    end else if (cal_wr_hit) begin
      cal_src_xtal_ff <= cal_wr.src_xtal;
      cal_reset_ff    <= cal_wr.cal_reset;
      cal_en_ff       <= cal_wr.enable;
    end
  end

  // Crystal runs at a quarter of 131 kHz, so the low-power side is divided to match
  assign ref_tick = cal_src_xtal_ff ? xtal_rise : prec_rise;
  assign lp_tick  = lp_rise && (!cal_src_xtal_ff || (lp_div_ff == cpcc_pkg::LP_DIV_LAST));
  assign ref_last = cal_running && ref_tick && (ref_cnt_ff == (cpcc_pkg::REF_CNT_END - 9'h1));

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lp_div_ff <= 2'h0;
    end else if (cal_start || cal_reset_ff) begin
      lp_div_ff <= 2'h0;
    end else if (cal_running && lp_rise) begin
      lp_div_ff <= lp_div_ff + 2'h1;
    end
  end

  // Run length is set by 511 reference edges: ~4 ms precision, ~16 ms crystal
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_cnt_ff <= 9'h000;
    end else if (cal_start || cal_reset_ff || (cal_wr_hit && cal_wr.clr_ref)) begin
      ref_cnt_ff <= 9'h000;
    end else if (cal_running && ref_tick) begin
      ref_cnt_ff <= ref_cnt_ff + 9'h001;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lp_cnt_ff <= 10'h000;
    end else if (cal_start || cal_reset_ff || (cal_wr_hit && cal_wr.clr_lp)) begin
      lp_cnt_ff <= 10'h000;
    end else if (cal_running && lp_tick) begin
      lp_cnt_ff <= lp_cnt_ff + 10'h001;
    end
  end

  // Both counters freeze once the reference count reaches its end value
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cal_stop_ff <= 1'b0;
    end else if (cal_start || cal_reset_ff) begin
      cal_stop_ff <= 1'b0;
    end else if (ref_last) begin
      cal_stop_ff <= 1'b1;
    end
  end

  assign lp_count_read = rd_in && (addr_in == cpcc_pkg::LP_CAL_COUNT_ADDR);

  // Completion set wins over a read in the same cycle
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cal_done_ff <= 1'b0;
    end else if (ref_last) begin
      cal_done_ff <= 1'b1;
    end else if (lp_count_read) begin
      cal_done_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cal_busy_ff <= 1'b0;
    end else begin
      cal_busy_ff <= cal_running && !ref_last;
    end
  end

  // Read path; key registers are write-only and read as zero
  always_comb begin
    nxt_rdata = 32'h0;
    case (addr_in)
      cpcc_pkg::POWER_MODE_ADDR:    nxt_rdata[7:0] = pmc_ff;
      cpcc_pkg::PLL_SOURCE_ADDR:    nxt_rdata[1:0] = pll_src_ff;
      cpcc_pkg::LP_TRIM_ADDR:       nxt_rdata[3:0] = trim_ff;
      cpcc_pkg::CAL_CONTROL_ADDR:   nxt_rdata[4:0] = {cal_src_xtal_ff, cal_reset_ff, 2'h0, cal_en_ff};
      cpcc_pkg::CAL_STATE_ADDR: begin
        nxt_rdata[cpcc_pkg::CAL_BUSY_BIT] = cal_busy_ff;
        nxt_rdata[cpcc_pkg::CAL_DONE_BIT] = cal_done_ff;
      end
      cpcc_pkg::REF_CAL_COUNT_ADDR: nxt_rdata[8:0] = ref_cnt_ff;
      cpcc_pkg::LP_CAL_COUNT_ADDR:  nxt_rdata[9:0] = lp_cnt_ff;
      default:                      nxt_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= rd_in ? nxt_rdata : 32'h0;
    end
  end

  assign rdata_out       = rdata_ff;
  assign power_ctrl_out  = pmc_ff;
  assign pll_ref_sel_out = pll_ref_sel_ff;
  assign lp_trim_out     = trim_ff;
  assign cal_busy_out    = cal_busy_ff;

endmodule

// ===== bench/cpcc_top_asserts.sv
// Port-level assertions for the clock and power control block
module cpcc_top_asserts (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rstn_in,
  input  wire logic [31:0]           addr_in,
  input  wire logic [31:0]           wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  input  wire logic [31:0]           rdata_out,
  input  wire logic                  wake_event_in,
  input  wire logic                  lp_osc_in,
  input  wire logic                  prec_osc_in,
  input  wire logic                  xtal_osc_in,
  input  wire cpcc_pkg::cpcc_power_t power_ctrl_out,
  input  wire logic [2:0]            pll_ref_sel_out,
  input  wire logic [3:0]            lp_trim_out,
  input  wire logic                  cal_busy_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rstn_in);

  chk_reset_values: assert property ($rose(rstn_in) |-> power_ctrl_out == 8'h79 &&
    pll_ref_sel_out == 3'h1 && lp_trim_out == 4'h8 && !cal_busy_out)
    else $error("outputs wrong after reset release");
  chk_read_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data not zero outside answer cycle");
  chk_key_reads_zero: assert property (rd_in && (addr_in == 32'hffff0404 ||
    addr_in == 32'hffff040c) |=> rdata_out == 32'h0)
    else $error("key register read not zero");
  chk_ref_onehot: assert property ($onehot(pll_ref_sel_out))
    else $error("reference select not one-hot");
  chk_power_chain: assert property ((!power_ctrl_out.core_en || power_ctrl_out.periph_en) &&
    (!power_ctrl_out.periph_en || power_ctrl_out.pll_en))
    else $error("power enables break core-periph-pll order");
  chk_power_cause: assert property ($changed(power_ctrl_out) |-> $past(wake_event_in) ||
    $past(wr_in && addr_in == 32'hffff040c, 2) || $past(wr_in && addr_in == 32'hffff040c, 3))
    else $error("power control changed without post key or wake");
  chk_trim_write: assert property (wr_in && addr_in == 32'hffff042c |=>
    lp_trim_out == $past(wdata_in[3:0]))
    else $error("trim not taken from write");
  chk_trim_read: assert property (rd_in && addr_in == 32'hffff042c |=>
    rdata_out == {28'h0, $past(lp_trim_out)})
    else $error("trim read back wrong");
  chk_busy_status: assert property (rd_in && addr_in == 32'hffff0444 |=>
    rdata_out[0] == $past(cal_busy_out))
    else $error("status busy bit differs from busy output");
endmodule

bind cpcc_top cpcc_top_asserts u_chk (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .wake_event_in(wake_event_in),
  .lp_osc_in(lp_osc_in), .prec_osc_in(prec_osc_in), .xtal_osc_in(xtal_osc_in),
  .power_ctrl_out(power_ctrl_out), .pll_ref_sel_out(pll_ref_sel_out),
  .lp_trim_out(lp_trim_out), .cal_busy_out(cal_busy_out)
);

// ===== bench/tb.sv
// Register-level testbench for the clock and power control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk_in;
  logic                  rstn_in;
  logic [31:0]           addr_in;
  logic [31:0]           wdata_in;
  logic                  wr_in;
  logic                  rd_in;
  logic [31:0]           rdata_out;
  logic                  wake_event_in;
  logic                  lp_osc_in = 1'b0;
  logic                  prec_osc_in = 1'b0;
  logic                  xtal_osc_in = 1'b0;
  cpcc_pkg::cpcc_power_t power_ctrl_out;
  logic [2:0]            pll_ref_sel_out;
  logic [3:0]            lp_trim_out;
  logic                  cal_busy_out;
  int                    n_mismatch;
  int                    checks;
  int                    half_lp;
  int                    ph_lp = 0;
  int                    ph_pr = 0;
  int                    ph_xt = 0;
  logic [31:0]           rv;
  logic [31:0]           lpc;
  logic [1:0]            c;

  cpcc_top dut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .wake_event_in(wake_event_in),
    .lp_osc_in(lp_osc_in), .prec_osc_in(prec_osc_in), .xtal_osc_in(xtal_osc_in),
    .power_ctrl_out(power_ctrl_out), .pll_ref_sel_out(pll_ref_sel_out),
    .lp_trim_out(lp_trim_out), .cal_busy_out(cal_busy_out)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  // Oscillators step on the bus clock; periods are far faster than real so a run stays short
  always @(posedge ref_clk_in) begin
    ph_lp <= (ph_lp >= half_lp - 1) ? 0 : ph_lp + 1;
    ph_pr <= (ph_pr >= 4) ? 0 : ph_pr + 1;
    ph_xt <= (ph_xt >= 11) ? 0 : ph_xt + 1;
    if (ph_lp >= half_lp - 1) lp_osc_in <= ~lp_osc_in;
    if (ph_pr >= 4) prec_osc_in <= ~prec_osc_in;
    if (ph_xt >= 11) xtal_osc_in <= ~xtal_osc_in;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    wr_in    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in   <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  // Key registers sit one word below and above the protected register
  task automatic kw(input logic [31:0] a, input logic [31:0] pre, input logic [7:0] d, input logic [31:0] post);
    wr(a - 32'h4, pre);
    wr(a, {24'h0, d});
    wr(a + 32'h4, post);
    repeat (4) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic cal_run(input logic [7:0] ctl);
    int n;
    logic [3:0] t;
    wr(cpcc_pkg::CAL_CONTROL_ADDR, {24'h0, ctl});
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk("busy at start", 32'h1, {31'h0, cal_busy_out});
    n = 0;
    while (cal_busy_out !== 1'b0 && n < 20000) begin
      @(posedge ref_clk_in);
      n++;
    end
    #1;
    chk("busy after run", 32'h0, {31'h0, cal_busy_out});
    rd(cpcc_pkg::CAL_STATE_ADDR, rv);
    chk("status done", 32'h2, rv);
    rd(cpcc_pkg::REF_CAL_COUNT_ADDR, rv);
    chk("reference count", 32'h1ff, rv);
    rd(cpcc_pkg::LP_CAL_COUNT_ADDR, lpc);
    chk("lp count near reference", 32'h1, {31'h0, lpc > 32'd505 && lpc < 32'd517});
    rd(cpcc_pkg::CAL_STATE_ADDR, rv);
    chk("status after count read", 32'h0, rv);
    rd(cpcc_pkg::LP_CAL_COUNT_ADDR, rv);
    chk("lp count held", lpc, rv);
    rd(cpcc_pkg::LP_TRIM_ADDR, rv);
    t = rv[3:0];
    if (lpc < 32'h1ff) t = t - 4'h1;
    if (lpc > 32'h1ff) t = t + 4'h1;
    wr(cpcc_pkg::LP_TRIM_ADDR, {28'h0, t});
    chk("trim after compare", {28'h0, t}, {28'h0, lp_trim_out});
    wr(cpcc_pkg::CAL_CONTROL_ADDR, 32'h0);
  endtask

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    rstn_in = 1'b0;
    addr_in = 32'h0;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    wake_event_in = 1'b0;
    half_lp = 5;
    n_mismatch = 0;
    checks = 0;
    repeat (16) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    fork
      begin
        #1;
        chk("power reset", 32'h79, {24'h0, power_ctrl_out});
        rd(cpcc_pkg::POWER_MODE_ADDR, rv);
        chk("power read", 32'h79, rv);
        rd(cpcc_pkg::PLL_SOURCE_ADDR, rv);
        chk("pll source read", 32'h0, rv);
        rd(cpcc_pkg::POWER_KEY_PRE_ADDR, rv);
        chk("key read", 32'h0, rv);
        wr(32'hffff0500, 32'hff);
        rd(32'hffff0500, rv);
        chk("unmapped read", 32'h0, rv);
        rd(cpcc_pkg::LP_TRIM_ADDR, rv);
        chk("trim reset", 32'h8, rv);
        wr(cpcc_pkg::LP_TRIM_ADDR, 32'hf5);
        chk("trim out", 32'h5, {28'h0, lp_trim_out});
        rd(cpcc_pkg::LP_TRIM_ADDR, rv);
        chk("trim read", 32'h5, rv);
        kw(cpcc_pkg::POWER_MODE_ADDR, cpcc_pkg::POWER_KEY_PRE_VAL, 8'hc7, cpcc_pkg::POWER_KEY_POST_VAL);
        chk("full power-down", 32'hc7, {24'h0, power_ctrl_out});
        @(posedge ref_clk_in);
        wake_event_in <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        wake_event_in <= 1'b0;
        #1;
        chk("wake sets enables", 32'hff, {24'h0, power_ctrl_out});
        for (int d = 0; d < 8; d++) begin
          kw(cpcc_pkg::POWER_MODE_ADDR, cpcc_pkg::POWER_KEY_PRE_VAL, 8'h38 | d[7:0], cpcc_pkg::POWER_KEY_POST_VAL);
          chk("core divider", 32'h38 | d, {24'h0, power_ctrl_out});
        end
        kw(cpcc_pkg::POWER_MODE_ADDR, cpcc_pkg::POWER_KEY_PRE_VAL, 8'h08, cpcc_pkg::POWER_KEY_POST_VAL);
        chk("core keeps periph and pll", 32'h38, {24'h0, power_ctrl_out});
        kw(cpcc_pkg::POWER_MODE_ADDR, cpcc_pkg::POWER_KEY_PRE_VAL, 8'h10, cpcc_pkg::POWER_KEY_POST_VAL);
        chk("periph keeps pll", 32'h30, {24'h0, power_ctrl_out});
        kw(cpcc_pkg::POWER_MODE_ADDR, 32'h2, 8'h07, cpcc_pkg::POWER_KEY_POST_VAL);
        chk("bad prewrite key", 32'h30, {24'h0, power_ctrl_out});
        kw(cpcc_pkg::POWER_MODE_ADDR, cpcc_pkg::POWER_KEY_PRE_VAL, 8'h07, 32'hf5);
        rd(cpcc_pkg::POWER_MODE_ADDR, rv);
        chk("bad postwrite key", 32'h30, rv);
        for (int i = 1; i < 5; i++) begin
          c = i[1:0];
          kw(cpcc_pkg::PLL_SOURCE_ADDR, cpcc_pkg::PLL_KEY_PRE_VAL, {6'h0, c}, cpcc_pkg::PLL_KEY_POST_VAL);
          chk("ref select", (c == 2'h1) ? 32'h2 : (c == 2'h2) ? 32'h4 : 32'h1, {29'h0, pll_ref_sel_out});
          rd(cpcc_pkg::PLL_SOURCE_ADDR, rv);
          chk("pll source", {30'h0, c}, rv);
        end
        kw(cpcc_pkg::PLL_SOURCE_ADDR, cpcc_pkg::PLL_KEY_PRE_VAL, 8'h01, 32'h54);
        chk("pll bad key", 32'h1, {29'h0, pll_ref_sel_out});
        kw(cpcc_pkg::PLL_SOURCE_ADDR, cpcc_pkg::PLL_KEY_PRE_VAL, 8'h01, cpcc_pkg::PLL_KEY_POST_VAL);
        wr(cpcc_pkg::CAL_CONTROL_ADDR, 32'h1);
        repeat (200) @(posedge ref_clk_in);
        wr(cpcc_pkg::CAL_CONTROL_ADDR, 32'h0);
        repeat (3) @(posedge ref_clk_in);
        rd(cpcc_pkg::CAL_STATE_ADDR, rv);
        chk("abort leaves idle", 32'h0, rv);
        rd(cpcc_pkg::REF_CAL_COUNT_ADDR, rv);
        chk("abort count short", 32'h1, {31'h0, rv < 32'h1ff});
        cal_run(8'h01);
        half_lp = 3;
        cal_run(8'h11);
        wr(cpcc_pkg::CAL_CONTROL_ADDR, 32'h6);
        rd(cpcc_pkg::REF_CAL_COUNT_ADDR, rv);
        chk("clear ref count", 32'h0, rv);
        rd(cpcc_pkg::LP_CAL_COUNT_ADDR, rv);
        chk("clear lp count", 32'h0, rv);
        wr(cpcc_pkg::CAL_CONTROL_ADDR, 32'h9);
        repeat (40) @(posedge ref_clk_in);
        rd(cpcc_pkg::CAL_CONTROL_ADDR, rv);
        chk("reset control readback", 32'h9, rv);
        rd(cpcc_pkg::REF_CAL_COUNT_ADDR, rv);
        chk("reset holds count", 32'h0, rv);
      end
      begin
        repeat (80000) @(posedge ref_clk_in);
        n_mismatch++;
        $display("[FAIL] run length expected end seen timeout");
      end
    join_any
    summarize();
  end
endmodule
